// [common/qrm_pkg.sv]
// Behaviour
// - irq when stored events reach threshold
// - threshold resets zero; zero disables irq
// - status bit reads one when buffer empty
// - status bit reads one when buffer full
// - status shows four-bit daughter board code
// - 24-bit tally, low 16 and high 8
// - mode bit 14 selects count every trigger
// - tally clears on clear, resets, and data reset when mode bit 14 is off
// - next-event strobe jumps to next event
// - next-word strobe steps one word, eob jumps
// - mode bit 11 enables self advance on reads
// - window is N/32 us plus 7 us
// - mode register writes of one set implemented bits
// - memory test bit allows direct memory writes
// - offline bit stops conversions
// - clear-data bit raises data reset
// - overflow check drops overflowed values
// - zero suppress keeps values at or above threshold
// - acquisition test bit selects test fifo
// - slide enable and subtraction disable bits
// - threshold step chooses times 2 or 16
// - empty enable writes header and eob
// - clear register resets bits written one
package qrm_pkg;
  // register offsets on the backplane port
  localparam logic [15:0] OFS_IRQ_THR    = 16'h1020;
  localparam logic [15:0] OFS_STATUS     = 16'h1022;
  localparam logic [15:0] OFS_TALLY_LO   = 16'h1024;
  localparam logic [15:0] OFS_TALLY_HI   = 16'h1026;
  localparam logic [15:0] OFS_NEXT_EVT   = 16'h1028;
  localparam logic [15:0] OFS_NEXT_WORD  = 16'h102A;
  localparam logic [15:0] OFS_WINDOW     = 16'h102E;
  localparam logic [15:0] OFS_MODE_SET   = 16'h1032;
  localparam logic [15:0] OFS_MODE_CLR   = 16'h1034;
  localparam logic [15:0] OFS_TALLY_CLR  = 16'h1040;
  // field widths
  localparam int THR_W    = 5;
  localparam int TALLY_W  = 24;
  localparam int LO_W     = 16;
  localparam int WIN_W    = 10;
  localparam int CODE_W   = 4;
  // operating mode bit positions
  localparam int MB_TEST_MEM  = 0;
  localparam int MB_OFFLINE   = 1;
  localparam int MB_CLR_DATA  = 2;
  localparam int MB_OVR_DIS   = 3;
  localparam int MB_ZS_DIS    = 4;
  localparam int MB_SYNTHETIC_EVENT_SOURCE  = 6;
  localparam int MB_SLD_EN    = 7;
  localparam int MB_THRESHOLD_RESOLUTION_SELECT   = 8;
  localparam int MB_AUTO_INC  = 11;
  localparam int MB_EMPTY_EN  = 12;
  localparam int MB_SLD_SUB   = 13;
  localparam int MB_COUNT_EVERY_TRIGGER   = 14;
  // implemented bits and their reset value
  localparam logic [15:0] MODE_MASK  = 16'h79DF;
  localparam logic [15:0] MODE_RESET = 16'h4880;
  // status register fields
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL  = 2;
  localparam int ST_CODE  = 4;
  // window timing, in 1/32 us ticks
  localparam int WIN_OFFSET_US   = 7;
  localparam int TICKS_PER_US    = 32;
  localparam int WIN_OFFSET_TICK = WIN_OFFSET_US * TICKS_PER_US;
  localparam int WIN_TICK_W      = 11;
  // suppression multipliers as shifts
  localparam int STEP_FINE_SH   = 1;
  localparam int STEP_COARSE_SH = 4;
  localparam int CONV_W = 12;
  localparam int CTHR_W = 8;
  // one backplane access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } qrm_bus_s;
  // decoded mode bits to the datapath
  typedef struct packed {
    logic test_mem;
    logic offline;
    logic synthetic_event_source;
    logic slide_dac_constant;
    logic slide_sub_disable;
    logic write_empty_event;
    logic pointer_self_advance;
    logic count_every_trigger;
  } qrm_mode_s;
endpackage

// [src/qrm_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module qrm_regs
  import qrm_pkg::*;
#(
  parameter logic [CODE_W-1:0] BOARD_CODE = 4'hA  // arbitrary value
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire qrm_bus_s              bus,
  output logic [15:0]                bus_rdata,
  input  wire logic                  sw_reset,
  input  wire logic                  ext_data_reset,
  input  wire logic                  trigger,
  input  wire logic                  trigger_accepted,
  input  wire logic [THR_W-1:0]      events_stored,
  input  wire logic                  buf_empty,
  input  wire logic                  buf_full,
  input  wire logic                  buf_word_read,
  input  wire logic                  end_of_block_word,
  input  wire logic [CONV_W-1:0]     conv_value,
  input  wire logic                  conv_overflow,
  input  wire logic [CTHR_W-1:0]     chan_threshold,
  output logic                       conv_store,
  output logic                       irq_request,
  output logic                       advance_event,
  output logic                       advance_word,
  output logic                       data_reset,
  output logic [WIN_TICK_W-1:0]      discard_window_time,
  output qrm_mode_s                  mode_out
);

  // register state
  logic [THR_W-1:0]   irq_event_threshold;  // reset zero
  logic [TALLY_W-1:0] event_tally;          // 24-bit tally
  logic [WIN_W-1:0]   window_n;             // window step count
  logic [15:0]        mode;                 // operating mode
  logic [15:0]        next_rdata;           // read mux

  // write decodes, one per write offset; the mode register has a set and a clear decode
  logic wr_thr;
  logic wr_evt;
  logic wr_word;
  logic wr_win;
  logic wr_set;
  logic wr_clr;
  logic wr_tclr;
  assign wr_thr  = bus.wr && (bus.addr == OFS_IRQ_THR);
  assign wr_evt  = bus.wr && (bus.addr == OFS_NEXT_EVT);
  assign wr_word = bus.wr && (bus.addr == OFS_NEXT_WORD);
  assign wr_win  = bus.wr && (bus.addr == OFS_WINDOW);
  assign wr_set  = bus.wr && (bus.addr == OFS_MODE_SET);
  assign wr_clr  = bus.wr && (bus.addr == OFS_MODE_CLR);
  assign wr_tclr = bus.wr && (bus.addr == OFS_TALLY_CLR);

  // threshold register
  always_ff @(posedge clk_sys) begin
    if (!resetn || sw_reset) begin
      irq_event_threshold <= '0;
    end else if (wr_thr) begin
      irq_event_threshold <= bus.wdata[THR_W-1:0];
    end
  end

  // zero threshold keeps the request quiet
  assign irq_request = (irq_event_threshold != '0) &&
                       (events_stored >= irq_event_threshold);

  // window register, lower ten bits kept
  always_ff @(posedge clk_sys) begin
    if (!resetn || sw_reset) begin
      window_n <= '0;
    end else if (wr_win) begin
      window_n <= bus.wdata[WIN_W-1:0];
    end
  end

  // window in 1/32 us ticks: N plus the fixed 7 us
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      discard_window_time <= WIN_TICK_W'(WIN_OFFSET_TICK);
    end else begin
      discard_window_time <= WIN_TICK_W'(window_n) +
                             WIN_TICK_W'(WIN_OFFSET_TICK);
    end
  end

  // operating mode: set port ors, clear port masks off
  always_ff @(posedge clk_sys) begin
    if (!resetn || sw_reset) begin
      mode <= MODE_RESET;
    end else if (wr_set) begin
      mode <= mode | (bus.wdata & MODE_MASK);
    end else if (wr_clr) begin
      mode <= mode & ~bus.wdata;
    end
  end

  // mode bits out to the datapath
  always_comb begin
    mode_out.test_mem             = mode[MB_TEST_MEM];
    mode_out.offline              = mode[MB_OFFLINE];
    mode_out.synthetic_event_source             = mode[MB_SYNTHETIC_EVENT_SOURCE];
    mode_out.slide_dac_constant   = !mode[MB_SLD_EN];
    mode_out.slide_sub_disable    = mode[MB_SLD_SUB];
    mode_out.write_empty_event    = mode[MB_EMPTY_EN];
    mode_out.pointer_self_advance = mode[MB_AUTO_INC];
    mode_out.count_every_trigger  = mode[MB_COUNT_EVERY_TRIGGER];
  end

  // data reset stands while clear-data is set, or from outside
  assign data_reset = mode[MB_CLR_DATA] || ext_data_reset;

  // tally clear: dedicated write, resets, or data reset when relative
  logic tally_clear;
  assign tally_clear = wr_tclr || sw_reset ||
                       (data_reset && !mode[MB_COUNT_EVERY_TRIGGER]);

  // tally counter; clear beats a same-cycle trigger
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      event_tally <= '0;
    end else if (tally_clear) begin
      event_tally <= '0;
    end else if (trigger && (mode[MB_COUNT_EVERY_TRIGGER] || trigger_accepted)) begin
      event_tally <= event_tally + TALLY_W'(1);
    end
  end

  // readout pointer steps; eob turns a word step into an event step
  logic step_word;
  assign step_word = wr_word ||
                     (mode[MB_AUTO_INC] && buf_word_read);
  assign advance_event = wr_evt || (step_word && end_of_block_word);
  assign advance_word  = step_word && !end_of_block_word;

  // store filter for one converted value
  logic [CONV_W+STEP_COARSE_SH-1:0] thr_scaled;
  logic below_thr;
  always_comb begin
    if (mode[MB_THRESHOLD_RESOLUTION_SELECT]) begin
      thr_scaled = (CONV_W+STEP_COARSE_SH)'(chan_threshold) << STEP_COARSE_SH;
    end else begin
      thr_scaled = (CONV_W+STEP_COARSE_SH)'(chan_threshold) << STEP_FINE_SH;
    end
  end
  assign below_thr = (CONV_W+STEP_COARSE_SH)'(conv_value) < thr_scaled;
  // overflow drop and zero suppression each have their own disable
  assign conv_store = (mode[MB_OVR_DIS] || !conv_overflow) &&
                      (mode[MB_ZS_DIS] || !below_thr);

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = '0;
    unique case (bus.addr)
      OFS_IRQ_THR: begin
        next_rdata[THR_W-1:0] = irq_event_threshold;
      end
      OFS_STATUS: begin
        next_rdata[ST_EMPTY] = buf_empty;
        next_rdata[ST_FULL]  = buf_full;
        next_rdata[ST_CODE +: CODE_W] = BOARD_CODE;
      end
      OFS_TALLY_LO: begin
        next_rdata = event_tally[LO_W-1:0];
      end
      OFS_TALLY_HI: begin
        next_rdata[TALLY_W-LO_W-1:0] = event_tally[TALLY_W-1:LO_W];
      end
      OFS_WINDOW: begin
        next_rdata[WIN_W-1:0] = window_n;
      end
      OFS_MODE_SET: begin
        next_rdata = mode;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // read data registered; valid the cycle after rd
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_rdata <= '0;
    end else if (bus.rd) begin
      bus_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_set_write;
    wr_set && !sw_reset;
  endsequence
  sequence s_clr_write;
    wr_clr && !sw_reset;
  endsequence

  chk_irq_zero_off: assert property (
    (irq_event_threshold == '0) |-> !irq_request)
    else $error("irq raised with zero threshold");
  chk_irq_reach: assert property (
    (irq_event_threshold != '0 && events_stored >= irq_event_threshold)
    |-> irq_request)
    else $error("irq missing at threshold");
  chk_mode_set_or: assert property (
    s_set_write |=> mode == ($past(mode) | ($past(bus.wdata) & MODE_MASK)))
    else $error("mode set write wrong");
  chk_mode_clr_and: assert property (
    s_clr_write |=> mode == ($past(mode) & ~$past(bus.wdata)))
    else $error("mode clear write wrong");
  chk_tally_clear: assert property (
    wr_tclr ##1 !tally_clear && !trigger |-> event_tally == '0)
    else $error("tally not cleared");
  chk_tally_count: assert property (
    (!tally_clear && trigger && !trigger_accepted && mode[MB_COUNT_EVERY_TRIGGER])
    |=> event_tally == $past(event_tally) + TALLY_W'(1))
    else $error("all-trigger count missed");
  chk_tally_rel: assert property (
    (!tally_clear && trigger && !trigger_accepted && !mode[MB_COUNT_EVERY_TRIGGER])
    |=> $stable(event_tally))
    else $error("relative count moved");
  chk_status_rd: assert property (
    (bus.rd && bus.addr == OFS_STATUS)
    |=> bus_rdata[ST_EMPTY] == $past(buf_empty) &&
        bus_rdata[ST_FULL] == $past(buf_full))
    else $error("status bits wrong");
  chk_eob_jump: assert property (
    (wr_word && end_of_block_word) |-> advance_event && !advance_word)
    else $error("eob step not an event step");
  chk_self_adv: assert property (
    (buf_word_read && !mode[MB_AUTO_INC] && !wr_word && !wr_evt)
    |-> !advance_word && !advance_event)
    else $error("pointer moved with self advance off");
  chk_window_val: assert property (
    wr_win && !sw_reset ##2 1 |-> discard_window_time ==
      WIN_TICK_W'($past(bus.wdata[WIN_W-1:0], 2)) + WIN_TICK_W'(WIN_OFFSET_TICK))
    else $error("window width wrong");
  chk_data_rst: assert property (
    mode[MB_CLR_DATA] |-> data_reset)
    else $error("clear-data without data reset");

  // full level reaches the status word
  chk_status_full: assert property (
    (bus.rd && bus.addr == OFS_STATUS && buf_full) |=> bus_rdata[ST_FULL])
    else $error("full bit not set");

  // board code reads back unchanged
  chk_code_rd: assert property (
    (bus.rd && bus.addr == OFS_STATUS) |=> bus_rdata[ST_CODE +: CODE_W] == BOARD_CODE)
    else $error("board code wrong");

  // low sixteen bits of the tally
  chk_tally_lo: assert property (
    (bus.rd && bus.addr == OFS_TALLY_LO) |=> bus_rdata == $past(event_tally[LO_W-1:0]))
    else $error("tally low read wrong");

  // upper eight bits, the rest zero
  chk_tally_hi: assert property (
    (bus.rd && bus.addr == OFS_TALLY_HI)
    |=> bus_rdata[15:TALLY_W-LO_W] == '0 &&
        bus_rdata[TALLY_W-LO_W-1:0] == $past(event_tally[TALLY_W-1:LO_W]))
    else $error("tally high read wrong");

  // read data holds between reads
  chk_rd_hold: assert property (
    !bus.rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");

  // next-event strobe always jumps
  chk_next_evt: assert property (
    wr_evt |-> advance_event)
    else $error("next-event strobe lost");

  // plain word step inside an event
  chk_word_step: assert property (
    (wr_word && !end_of_block_word) |-> advance_word && !advance_event)
    else $error("word step missing");

  // self advance follows buffer reads
  chk_self_on: assert property (
    (buf_word_read && mode[MB_AUTO_INC] && !end_of_block_word) |-> advance_word)
    else $error("self advance missing");

  // threshold write lands next cycle
  chk_thr_write: assert property (
    (wr_thr && !sw_reset) |=> irq_event_threshold == $past(bus.wdata[THR_W-1:0]))
    else $error("threshold write lost");

  // software reset restores defaults
  chk_sw_defaults: assert property (
    sw_reset |=> mode == MODE_RESET && event_tally == '0 &&
                 irq_event_threshold == '0)
    else $error("software reset left state");

  // relative counter clears on data reset
  chk_tally_drst: assert property (
    (data_reset && !mode[MB_COUNT_EVERY_TRIGGER]) |=> event_tally == '0)
    else $error("relative tally survived data reset");

  // all-trigger counter ignores data reset
  chk_tally_keep: assert property (
    (ext_data_reset && mode[MB_COUNT_EVERY_TRIGGER] && !wr_tclr && !sw_reset && !trigger)
    |=> $stable(event_tally))
    else $error("all-trigger tally cleared by data reset");

  // overflowed values dropped while the check is on
  chk_store_ovr: assert property (
    (conv_overflow && !mode[MB_OVR_DIS]) |-> !conv_store)
    else $error("overflowed value stored");

  // both checks off keeps everything
  chk_store_all: assert property (
    (mode[MB_ZS_DIS] && mode[MB_OVR_DIS]) |-> conv_store)
    else $error("value dropped with checks off");

  // fine step: below twice the threshold is dropped
  chk_step_fine: assert property (
    (!mode[MB_ZS_DIS] && !mode[MB_THRESHOLD_RESOLUTION_SELECT] &&
     (conv_value >> STEP_FINE_SH) < CONV_W'(chan_threshold)) |-> !conv_store)
    else $error("fine step value kept");

  // coarse step: below sixteen times the threshold is dropped
  chk_step_coarse: assert property (
    (!mode[MB_ZS_DIS] && mode[MB_THRESHOLD_RESOLUTION_SELECT] &&
     (conv_value >> STEP_COARSE_SH) < CONV_W'(chan_threshold)) |-> !conv_store)
    else $error("coarse step value kept");

  // empty-event option reaches the datapath
  chk_empty_map: assert property (
    mode[MB_EMPTY_EN] |-> mode_out.write_empty_event)
    else $error("empty-event option lost");

endmodule
`default_nettype wire

// [dv/qrm_buf_model.sv]
`timescale 1ns/1ns
`default_nettype none
module qrm_buf_model
  import qrm_pkg::*;
#(
  parameter int DEPTH = 4  // events held; small so full is reached fast
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             add_event,
  input  wire logic             advance_event,
  input  wire logic             data_reset,
  output logic [THR_W-1:0]      events_stored,
  output logic                  buf_empty,
  output logic                  buf_full
);
  // event count; a drain wins over a new event
  always_ff @(posedge clk_sys) begin
    if (!resetn || data_reset) begin
      events_stored <= '0;
    end else if (advance_event && events_stored != '0) begin
      events_stored <= events_stored - 1'b1;
    end else if (add_event && events_stored != DEPTH[THR_W-1:0]) begin
      events_stored <= events_stored + 1'b1;
    end
  end
  // levels follow the count
  assign buf_empty = (events_stored == '0);
  assign buf_full  = (events_stored == DEPTH[THR_W-1:0]);
endmodule
`default_nettype wire

// [dv/qrm_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module qrm_regs_tb
  import qrm_pkg::*;
;
  logic clk_sys, resetn, sw_reset, ext_data_reset, trigger, trigger_accepted;
  logic buf_word_read, end_of_block_word, conv_overflow, conv_store, irq_request;
  logic advance_event, advance_word, data_reset, add_event, buf_empty, buf_full;
  logic [15:0]         bus_rdata, v;
  logic [THR_W-1:0]    events_stored;
  logic [CONV_W-1:0]   conv_value;
  logic [CTHR_W-1:0]   chan_threshold;
  logic [WIN_TICK_W-1:0] discard_window_time;
  qrm_bus_s            bus;
  qrm_mode_s           mode_out;
  logic                ae, aw;
  int                  err_count, checks_done;
  // board code chosen away from the default, value arbitrary
  qrm_regs #(.BOARD_CODE(4'h5)) dut (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
    .bus_rdata(bus_rdata), .sw_reset(sw_reset), .ext_data_reset(ext_data_reset),
    .trigger(trigger), .trigger_accepted(trigger_accepted),
    .events_stored(events_stored), .buf_empty(buf_empty), .buf_full(buf_full),
    .buf_word_read(buf_word_read), .end_of_block_word(end_of_block_word),
    .conv_value(conv_value), .conv_overflow(conv_overflow),
    .chan_threshold(chan_threshold), .conv_store(conv_store),
    .irq_request(irq_request), .advance_event(advance_event),
    .advance_word(advance_word), .data_reset(data_reset),
    .discard_window_time(discard_window_time), .mode_out(mode_out));
  qrm_buf_model bm (.clk_sys(clk_sys), .resetn(resetn), .add_event(add_event),
    .advance_event(advance_event), .data_reset(data_reset),
    .events_stored(events_stored), .buf_empty(buf_empty), .buf_full(buf_full));
  // 100 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wr, rd, pulse and trig end 1 ns after an edge and start 1 to 4 ns after one
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    #1;
    ae = advance_event;  // strobes live only in the write cycle
    aw = advance_word;
    @(posedge clk_sys);
    #1;
    bus.wr = 1'b0;
    // idle cycle so a following call never re-raises wr in this step
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    bus.rd = 1'b1;
    bus.addr = a;
    @(posedge clk_sys);
    #1;
    bus.rd = 1'b0;
    d = bus_rdata;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk_sys);
    #1;
    s = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic trig(input logic acc, input int n);
    trigger_accepted = acc;
    repeat (n) pulse(trigger);
  endtask
  task automatic filt(input logic [11:0] cv, input logic ov, input logic exp);
    conv_value = cv;
    conv_overflow = ov;
    #1;
    chk(16'(conv_store), 16'(exp));
  endtask
  // watchdog, well beyond the hundred or so cycles used
  initial begin
    #(5000 * 100);
    err_count++;
    test_done();
  end
  initial begin
    {sw_reset, ext_data_reset, trigger, trigger_accepted, buf_word_read} = '0;
    {end_of_block_word, conv_overflow, add_event, resetn} = '0;
    {conv_value, chan_threshold, bus} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1'b1;
    rd(OFS_IRQ_THR, v); chk(v, 16'h0000);
    rd(OFS_MODE_SET, v); chk(v, 16'h4880);
    chk(16'(discard_window_time), 16'h00E0);
    rd(OFS_STATUS, v); chk(v & 16'h00F6, 16'h0052);
    // tally in both counting modes and its clears
    trig(1'b0, 3);
    rd(OFS_TALLY_LO, v); chk(v, 16'h0003);
    rd(OFS_TALLY_HI, v); chk(v, 16'h0000);
    wr(OFS_MODE_CLR, 16'h4000);
    trig(1'b0, 2);
    trig(1'b1, 1);
    rd(OFS_TALLY_LO, v); chk(v, 16'h0004);
    pulse(ext_data_reset);
    rd(OFS_TALLY_LO, v); chk(v, 16'h0000);
    trig(1'b1, 2);
    wr(OFS_MODE_SET, 16'h0004);
    chk(16'(data_reset), 16'h0001);
    wr(OFS_MODE_CLR, 16'h0004);
    rd(OFS_TALLY_LO, v); chk(v, 16'h0000);
    trig(1'b1, 1);
    wr(OFS_TALLY_CLR, 16'h0000);
    rd(OFS_TALLY_LO, v); chk(v, 16'h0000);
    // threshold and buffer levels
    repeat (2) pulse(add_event);
    chk(16'(irq_request), 16'h0000);
    wr(OFS_IRQ_THR, 16'h0003);
    chk(16'(irq_request), 16'h0000);
    pulse(add_event);
    chk(16'(irq_request), 16'h0001);
    pulse(add_event);
    rd(OFS_STATUS, v); chk(v & 16'h0006, 16'h0004);
    // strobes and self advance
    wr(OFS_NEXT_EVT, 16'h0000); chk(16'({ae, aw}), 16'h0002);
    wr(OFS_NEXT_WORD, 16'h0000); chk(16'({ae, aw}), 16'h0001);
    wr(OFS_MODE_CLR, 16'h0800);
    buf_word_read = 1'b1;
    #1 chk(16'(advance_word), 16'h0000);
    @(posedge clk_sys);
    #1 buf_word_read = 1'b0;
    wr(OFS_WINDOW, 16'h03FF);
    chk(16'(discard_window_time), 16'h04DF);
    // set-only mode bits, zeros leave them alone
    wr(OFS_MODE_SET, 16'h3843);
    wr(OFS_MODE_SET, 16'h0000);
    wr(OFS_MODE_CLR, 16'h0080);
    rd(OFS_MODE_SET, v); chk(v, 16'h3843);
    chk(16'(mode_out), 16'h00FE);
    // value filtering
    chan_threshold = 8'h0A;
    filt(12'h013, 1'b0, 1'b0);
    filt(12'h014, 1'b0, 1'b1);
    filt(12'h014, 1'b1, 1'b0);
    wr(OFS_MODE_SET, 16'h0108);
    filt(12'h09F, 1'b1, 1'b0);
    filt(12'h0A0, 1'b1, 1'b1);
    wr(OFS_MODE_SET, 16'h0010);
    filt(12'h000, 1'b0, 1'b1);
    // software reset restores defaults
    trig(1'b1, 1);
    pulse(sw_reset);
    rd(OFS_MODE_SET, v); chk(v, 16'h4880);
    rd(OFS_TALLY_LO, v); chk(v, 16'h0000);
    rd(OFS_IRQ_THR, v); chk(v, 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
